// ---- verilog/vxs_defs.svh ----
// constants for the vectored exception sequencer
`ifndef VXS_DEFS_SVH
`define VXS_DEFS_SVH

`define VXS_NUM_VEC      128
`define VXS_TABLE_SIZE   256
`define VXS_WORD_W       24
`define VXS_OFS_RESET    8'h00
`define VXS_OFS_STACK    8'h02
`define VXS_OFS_ILLEGAL  8'h04
`define VXS_OFS_DEBUG    8'h06
`define VXS_OFS_TRAP     8'h08
`define VXS_OFS_NMI      8'h0a
`define VXS_OFS_RSVD0    8'h0c
`define VXS_OFS_RSVD1    8'h0e
`define VXS_OFS_EXTA     8'h10
`define VXS_OFS_DMA0     8'h18
`define VXS_OFS_PERIPH1  8'h24
`define VXS_OFS_LAST     8'hfe
`define VXS_SRC_RSVD0    7'h06
`define VXS_SRC_RSVD1    7'h07
`define VXS_SRC_EXTA     7'h08
`define VXS_LVL_NMASK    2'h3
// the match must lie inside the mask or no word is ever a jump
`define VXS_SUBJ_MASK    24'hff0000
`define VXS_SUBJ_MATCH   24'h0d0000

`endif

// ---- verilog/vxs_pkg.sv ----
// types shared by the vectored exception sequencer
package vxs_pkg;

  typedef enum logic [2:0] {
    VXS_NORMAL  = 3'b000,
    VXS_FETCH0  = 3'b001,
    VXS_FETCH1  = 3'b010,
    VXS_INSERT  = 3'b011,
    VXS_WAIT    = 3'b100,
    VXS_STOP    = 3'b101
  } vxs_state_type;

  typedef struct packed {
    logic        valid;
    logic [6:0]  source;
    logic [1:0]  level;
  } vxs_grant_type;

  typedef struct packed {
    logic        req;
    logic [23:0] addr;
  } vxs_fetch_type;

endpackage

// ---- verilog/vxs_arbiter.sv ----
// priority arbiter over pending exception sources
`timescale 1ns/10ps
`include "vxs_defs.svh"

module vxs_arbiter
  import vxs_pkg::*;
(
  // pending state
  input  wire logic [127:0] pending,
  input  wire logic [255:0] levels,
  // status word mask
  input  wire logic [1:0]   mask_level_bits,
  // result
  output vxs_grant_type     grant
);

  // -------------------------------------------------------------------
  // arbitration
  // -------------------------------------------------------------------
  // level first, then lowest index; scanning downward keeps the lowest
  always_comb begin
    grant = '0;
    for (int lv = 0; lv < 4; lv++) begin
      for (int i = 127; i >= 0; i--) begin
        if (pending[i] && levels[2*i +: 2] == lv[1:0] &&
            (lv[1:0] >= mask_level_bits ||
             lv[1:0] == `VXS_LVL_NMASK) &&
            i != 6 && i != 7) begin
          grant.valid  = 1'b1;
          grant.source = i[6:0];
          grant.level  = lv[1:0];
        end
      end
    end
  end

endmodule

// ---- verilog/vxs_sequencer.sv ----
// vectored exception sequencer top: pending flags, fetch and insertion
`timescale 1ns/10ps
`include "vxs_defs.svh"

// Functional notes
// - each hardware request is synchronised, then sets its pending flag
// - a source holds at most one pending request, no queueing
// - arbiter drops requests below mask, picks highest remaining level
// - after selection freeze the program counter and fetch two words
// - insert both words, release program counter, rearbitrate
// - no subroutine jump in either word means fast, nothing pushed
// - a subroutine jump means long: release, push status and counter
// - every subroutine jump form, conditional or bit test, makes it long
// - 128 two-word vectors; address is base pointer plus source offset
// - first word from the start address, second from the next
// - level-3 offsets 00 to 0a fixed, 0c and 0e reserved
// - maskable offsets: external 10-16, dma 18-22, peripherals 24-fe
// - four levels; level 3 unmaskable, ties ranked within level
// - reset halts execution and restores predetermined values
// - wait stops most work until a qualifying event; clock runs
// - stop halts all; only reset, debug pin or request a wake it
// - requests below the two status mask bits are inhibited
// - at equal level the lower vector offset wins
// - edge requests latch on a falling edge, clear when serviced
// - a serviced internal request has its pending flag cleared

module vxs_sequencer
  import vxs_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // core requests, index = vector offset / 2
  input  wire logic [127:0] request_lines,
  input  wire logic [127:0] edge_mode,
  input  wire logic [255:0] source_levels,
  // external request a and debug pin wake stop
  input  wire logic         external_request_a,
  input  wire logic         debug_event_pin,
  // status word and vector base pointer
  input  wire logic [23:0]  status_word,
  input  wire logic [23:0]  vector_base_pointer,
  // processing state commands from decode
  input  wire logic         wait_cmd,
  input  wire logic         stop_cmd,
  input  wire logic         reset_cmd,
  // fetch pipeline
  output vxs_fetch_type     vector_fetch,
  input  wire logic         fetch_ack,
  input  wire logic [23:0]  fetch_data,
  // insertion into the instruction stream
  output logic              insert_valid,
  output logic [23:0]       insert_word0,
  output logic [23:0]       insert_word1,
  output logic              insert_long,
  output logic [6:0]        insert_source,
  output logic              push_context,
  // program counter and core control
  output logic              program_counter_freeze,
  output logic              core_halt,
  output logic              core_reset,
  output logic              clock_gate
);

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  // any subroutine-jump family opcode, conditional and bit-test too
  function automatic logic is_subroutine_jump(input logic [23:0] w);
    is_subroutine_jump = (w & `VXS_SUBJ_MASK) == `VXS_SUBJ_MATCH;
  endfunction

  function automatic logic [23:0] vector_addr(input logic [23:0] base,
                                              input logic [6:0]  src);
    vector_addr = base + {16'h0000, src, 1'b0};
  endfunction

  // -------------------------------------------------------------------
  // synchronisers and edge detection
  // -------------------------------------------------------------------
  logic [127:0] sync1_q;
  logic [127:0] sync2_q;
  logic [127:0] sync3_q;
  logic [1:0]   prime_q;

  // level sources are ignored until the chain holds real samples, since
  // the idle-high reset value would otherwise pend every level source
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
      prime_q <= '0;
    end else begin
      prime_q <= {prime_q[0], 1'b1};
      sync1_q <= request_lines;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // level sources assert high; edge sources fire on a falling transition
  logic [127:0] raw_event;
  always_comb begin
    for (int i = 0; i < 128; i++) begin
      if (edge_mode[i]) begin
        raw_event[i] = sync3_q[i] & ~sync2_q[i];
      end else begin
        raw_event[i] = sync2_q[i] & prime_q[1];
      end
    end
  end

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  vxs_state_type state_q;
  vxs_grant_type grant;
  vxs_grant_type sel_q;
  logic [127:0]  pending_q;
  logic [127:0]  service_clr;
  logic [23:0]   word0_q;
  logic [23:0]   word1_q;

  vxs_arbiter u_arb (
    .pending         (pending_q),
    .levels          (source_levels),
    .mask_level_bits (status_word[9:8]),
    .grant           (grant)
  );

  // -------------------------------------------------------------------
  // pending flags
  // -------------------------------------------------------------------
  always_comb begin
    service_clr = '0;
    if (state_q == VXS_FETCH0) begin
      service_clr[sel_q.source] = 1'b1;
    end
  end

  // one flag per source; a repeat while set just stays set
  // the clear repeats every FETCH0 cycle; a fresh edge survives only in the last one
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending_q <= '0;
    end else if (reset_cmd) begin
      pending_q <= '0;
    end else begin
      pending_q <= (pending_q & ~service_clr) | raw_event;
    end
  end

  // -------------------------------------------------------------------
  // sequencer
  // -------------------------------------------------------------------
  logic wake_wait;
  logic wake_stop;
  assign wake_wait = grant.valid;
  assign wake_stop = debug_event_pin | ~external_request_a;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= VXS_NORMAL;
      sel_q   <= '0;
    end else if (reset_cmd) begin
      state_q <= VXS_NORMAL;
      sel_q   <= '0;
    end else begin
      unique case (state_q)
        VXS_NORMAL: begin
          if (grant.valid) begin
            sel_q   <= grant;
            state_q <= VXS_FETCH0;
          end else if (stop_cmd) begin
            state_q <= VXS_STOP;
          end else if (wait_cmd) begin
            state_q <= VXS_WAIT;
          end
        end
        VXS_FETCH0: begin
          if (fetch_ack) begin
            state_q <= VXS_FETCH1;
          end
        end
        VXS_FETCH1: begin
          if (fetch_ack) begin
            state_q <= VXS_INSERT;
          end
        end
        VXS_INSERT: begin
          state_q <= VXS_NORMAL;
        end
        VXS_WAIT: begin
          if (wake_wait) begin
            state_q <= VXS_NORMAL;
          end
        end
        VXS_STOP: begin
          if (wake_stop) begin
            state_q <= VXS_NORMAL;
          end
        end
        default: begin
          state_q <= VXS_NORMAL;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // vector word capture
  // -------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word0_q <= '0;
      word1_q <= '0;
    end else begin
      if (state_q == VXS_FETCH0 && fetch_ack) begin
        word0_q <= fetch_data;
      end
      if (state_q == VXS_FETCH1 && fetch_ack) begin
        word1_q <= fetch_data;
      end
    end
  end

  // -------------------------------------------------------------------
  // fetch request
  // -------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      vector_fetch <= '0;
    end else if (reset_cmd) begin
      vector_fetch <= '0;
    end else if (state_q == VXS_NORMAL && grant.valid) begin
      vector_fetch.req  <= 1'b1;
      vector_fetch.addr <= vector_addr(vector_base_pointer, grant.source);
    end else if (state_q == VXS_FETCH0 && fetch_ack) begin
      vector_fetch.addr <= vector_fetch.addr + 24'h000001;
    end else if (state_q == VXS_FETCH1 && fetch_ack) begin
      vector_fetch <= '0;
    end
  end

  // -------------------------------------------------------------------
  // insertion outputs
  // -------------------------------------------------------------------
  logic long_type;
  assign long_type = is_subroutine_jump(word0_q) |
                     is_subroutine_jump(word1_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      insert_valid  <= 1'b0;
      insert_word0  <= '0;
      insert_word1  <= '0;
      insert_long   <= 1'b0;
      insert_source <= '0;
      push_context  <= 1'b0;
    end else begin
      insert_valid <= state_q == VXS_INSERT;
      push_context <= state_q == VXS_INSERT && long_type;
      if (state_q == VXS_INSERT) begin
        insert_word0  <= word0_q;
        insert_word1  <= word1_q;
        insert_long   <= long_type;
        insert_source <= sel_q.source;
      end
    end
  end

  // -------------------------------------------------------------------
  // core control
  // -------------------------------------------------------------------
  // program counter held from selection until the pair is handed over
  assign program_counter_freeze = state_q == VXS_FETCH0 ||
                                  state_q == VXS_FETCH1 ||
                                  state_q == VXS_INSERT;
  assign core_halt  = state_q == VXS_WAIT || state_q == VXS_STOP;
  assign clock_gate = state_q == VXS_STOP;
  assign core_reset = reset | reset_cmd;

endmodule

// ---- verif/vxs_sequencer_assertions.sv ----
// port checker for the vectored exception sequencer
`timescale 1ns/10ps
`include "vxs_defs.svh"

module vxs_sequencer_assertions
  import vxs_pkg::*;
(
  // clock and reset
  input wire logic          clk,
  input wire logic          reset,
  input wire logic          reset_cmd,
  input wire logic          core_reset,
  // fetch side
  input wire logic [23:0]   vector_base_pointer,
  input wire vxs_fetch_type vector_fetch,
  input wire logic          fetch_ack,
  input wire logic          program_counter_freeze,
  // insertion side
  input wire logic          insert_valid,
  input wire logic [23:0]   insert_word0,
  input wire logic [23:0]   insert_word1,
  input wire logic          insert_long,
  input wire logic [6:0]    insert_source,
  input wire logic          push_context
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_freeze;
    vector_fetch.req |-> program_counter_freeze;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("counter not frozen during vector fetch");
  property p_hold;
    vector_fetch.req && !fetch_ack |=>
      vector_fetch.req && $stable(vector_fetch.addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("fetch request dropped or moved before answer");
  property p_second;
    (vector_fetch.req && fetch_ack) ##1 vector_fetch.req |->
      vector_fetch.addr == $past(vector_fetch.addr) + 24'h1;
  endproperty
  a_second: assert property (p_second)
    else $error("second vector word not from next address");
  property p_table;
    $rose(vector_fetch.req) |->
      ((vector_fetch.addr - vector_base_pointer) & 24'hffff01) == 24'h0;
  endproperty
  a_table: assert property (p_table)
    else $error("vector start outside table or odd");
  property p_insert;
    (vector_fetch.req && fetch_ack) ##1 !vector_fetch.req |->
      ##[0:2] insert_valid;
  endproperty
  a_insert: assert property (p_insert)
    else $error("vector words not inserted after fetch");
  property p_long;
    insert_valid |-> insert_long ==
      (((insert_word0 & `VXS_SUBJ_MASK) == `VXS_SUBJ_MATCH) ||
       ((insert_word1 & `VXS_SUBJ_MASK) == `VXS_SUBJ_MATCH));
  endproperty
  a_long: assert property (p_long)
    else $error("long flag disagrees with inserted words");
  property p_push;
    insert_valid |-> push_context == insert_long;
  endproperty
  a_push: assert property (p_push)
    else $error("context push disagrees with interrupt kind");
  property p_lone_push;
    push_context |-> insert_valid;
  endproperty
  a_lone_push: assert property (p_lone_push)
    else $error("context push without insertion");
  property p_reserved;
    insert_valid |-> insert_source != `VXS_SRC_RSVD0 &&
      insert_source != `VXS_SRC_RSVD1;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved vector slot serviced");
  property p_excl;
    insert_valid |-> !vector_fetch.req;
  endproperty
  a_excl: assert property (p_excl)
    else $error("fetch running during insertion");
  property p_rst;
    reset_cmd |-> core_reset;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset command did not reset core");
endmodule

bind vxs_sequencer vxs_sequencer_assertions chk_u (
  .clk(clk), .reset(reset), .reset_cmd(reset_cmd),
  .core_reset(core_reset), .vector_base_pointer(vector_base_pointer),
  .vector_fetch(vector_fetch), .fetch_ack(fetch_ack),
  .program_counter_freeze(program_counter_freeze),
  .insert_valid(insert_valid),
  .insert_word0(insert_word0), .insert_word1(insert_word1),
  .insert_long(insert_long), .insert_source(insert_source),
  .push_context(push_context));

// ---- verif/vxs_fetch_model.sv ----
// fetch pipeline model answering vector word fetches
`timescale 1ns/10ps

module vxs_fetch_model
  import vxs_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // request and answer
  input  wire vxs_fetch_type fetch,
  input  wire logic [3:0]    delay,
  input  wire logic [1:0]    subj_sel,
  output logic               ack,
  output logic [23:0]        data
);
  logic [3:0] cnt_q;

  // one idle cycle after each answer so a stale address is never answered;
  // data toggles off the answer cycle so stale words cannot pass
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack   <= 1'b0;
      cnt_q <= 4'h0;
      data  <= 24'h0;
    end else if (fetch.req && !ack && cnt_q >= delay) begin
      ack   <= 1'b1;
      cnt_q <= 4'h0;
      data  <= subj_sel[fetch.addr[0]] ? {8'h0d, fetch.addr[15:0]}
                                      : {4'h1, fetch.addr[19:0]};
    end else begin
      ack   <= 1'b0;
      cnt_q <= (fetch.req && !ack) ? cnt_q + 4'h1 : 4'h0;
      data  <= ~data;
    end
  end
endmodule

// ---- verif/vxs_sequencer_tb.sv ----
// self-checking bench for the vectored exception sequencer
`timescale 1ns/10ps

module vxs_sequencer_tb;
  import vxs_pkg::*;
  logic          clk, reset, ext_a, dbg, wt, st, rc, ack, iv, il, push;
  logic          frz, halt, crst, gate;
  logic [127:0]  rq, em;
  logic [255:0]  lvl;
  logic [23:0]   sw, base, dat, w0, w1;
  logic [1:0]    jsel;
  logic [3:0]    dly;
  logic [6:0]    isrc;
  vxs_fetch_type vf;
  int            fail_count, comparisons, s;

  vxs_sequencer dut_u (.clk(clk), .reset(reset), .request_lines(rq),
    .edge_mode(em), .source_levels(lvl), .external_request_a(ext_a),
    .debug_event_pin(dbg), .status_word(sw), .vector_base_pointer(base),
    .wait_cmd(wt), .stop_cmd(st), .reset_cmd(rc), .vector_fetch(vf),
    .fetch_ack(ack), .fetch_data(dat), .insert_valid(iv),
    .insert_word0(w0), .insert_word1(w1), .insert_long(il),
    .insert_source(isrc), .push_context(push),
    .program_counter_freeze(frz),
    .core_halt(halt), .core_reset(crst), .clock_gate(gate));
  vxs_fetch_model far_u (.clk(clk), .reset(reset), .fetch(vf), .delay(dly),
    .subj_sel(jsel), .ack(ack), .data(dat));

  // ---------------------------------
  // helpers
  // ---------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return jsel[a[0]] ? {8'h0d, a[15:0]} : {4'h1, a[19:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // sources idle high; a falling edge latches the request
  task automatic fire(input int a, input int b);
    rq[a] = 1'b0;
    rq[b] = 1'b0;
    tick(1);
    rq[a] = 1'b1;
    rq[b] = 1'b1;
  endtask
  task automatic grant(input int src);
    int n;
    logic [23:0] a;
    n = 0;
    while (iv !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      fail_count++;
      close_out();
    end
    a = base + 24'(2 * src);
    check(32'(isrc), 32'(src));
    check(32'(w0), 32'(word_at(a)));
    check(32'(w1), 32'(word_at(a + 24'h1)));
    check(32'(il), 32'(jsel != 2'b00));
    check(32'(push), 32'(jsel != 2'b00));
    tick(1);
    $display("serviced source %0d", src);
  endtask
  task automatic none(input int n);
    repeat (n) begin
      tick(1);
      check(32'(iv), 32'h0);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial begin
    {reset, ext_a, rq} = '1;
    // source 9 is level mode, idle low; reset must not pend it
    em = '1;
    em[9] = 1'b0;
    rq[9] = 1'b0;
    {dbg, wt, st, rc, jsel, dly, sw, base, fail_count, comparisons} = '0;
    lvl = {{240{1'b0}}, {16{1'b1}}};
    s = $urandom(86);
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    tick(2);
    check(32'(vf), 32'h0);
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 8 : (i == 1) ? 127 : 10 + $urandom % 118;
      jsel = 2'($urandom);
      dly = 4'($urandom);
      base = 24'($urandom) & 24'hfffffe;
      lvl[2*s +: 2] = 2'($urandom % 3);
      fire(s, s);
      grant(s);
    end
    lvl[40 +: 2] = 2'h1;
    lvl[60 +: 2] = 2'h1;
    lvl[80 +: 2] = 2'h2;
    fire(30, 20);
    grant(20);
    grant(30);
    fire(30, 40);
    grant(40);
    grant(30);
    fire(6, 6);
    none(30);
    sw = 24'h300;
    fire(40, 40);
    none(30);
    fire(5, 5);
    grant(5);
    sw = 24'h200;
    grant(40);
    fire(20, 20);
    none(30);
    sw = 24'h0;
    grant(20);
    for (int k = 0; k < 2; k++) begin
      st = 1'b1;
      tick(1);
      st = 1'b0;
      tick(6);
      check(32'({halt, gate}), 32'h3);
      dbg = (k == 0);
      ext_a = (k == 0);
      s = 0;
      while (halt !== 1'b0 && s < 50) begin
        tick(1);
        s++;
      end
      check(32'(halt), 32'h0);
      {dbg, ext_a} = 2'b01;
      tick(2);
    end
    rq[9] = 1'b1;
    tick(1);
    rq[9] = 1'b0;
    grant(9);
    wt = 1'b1;
    tick(1);
    wt = 1'b0;
    tick(2);
    check(32'({halt, gate}), 32'h2);
    fire(20, 20);
    grant(20);
    check(32'(halt), 32'h0);
    rc = 1'b1;
    #2;
    check(32'(crst), 32'h1);
    tick(1);
    rc = 1'b0;
    tick(4);
    close_out();
  end
endmodule
